/* File: design/sews_eeprom.v */
`timescale 1ns/1ps
`include "sews_eeprom_map.vh"

// What this block does
// - Sixteen bytes of storage, addressed by a pointer loaded over the serial bus.
// - Data line is port bit 6, clock line bit 7, port at index 06h.
// - Data line open-drain with pull-up, clock push-pull, both high after reset.
// - Data changes only while clock low; changes while high mean start or stop.
// - Data falling while clock high is a start; commands begin with it.
// - Data rising while clock high is a stop; operations end with it.
// - Both lines high means idle; transfers begin only then.
// - One bit per clock pulse, sampled while clock is high.
// - Receiver acknowledges every byte on an extra clock pulse from the master.
// - Acknowledger holds data low through the acknowledge clock high phase.
// - Master withholds acknowledge on last read byte; memory then leaves data high.
// - Final control bit one means read, zero means write.
// - Acknowledge control byte only on code match and no write cycle running.
// - Byte after write control loads pointer from low four bits, then acknowledged.
// - Stop after acknowledged data starts the write; pointer is not incremented.
// - Stop before the sequence completes, or mid later byte, aborts the write.
// - More than eight data bits discard the loaded byte and refill the buffer.
// - Master polls with start plus write control byte until acknowledged.
module sews_eeprom #(
    parameter WRITE_CYCLES = `SEWS_TWR_US * `SEWS_CLK_MHZ
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [`SEWS_ADDR_W-1:0] paddr,
    input wire [`SEWS_DATA_W-1:0] pwdata,
    output reg [`SEWS_DATA_W-1:0] prdata,
    output wire pready,
    output wire pslverr,
    output wire scl_line,
    output wire sda_line,
    output wire mem_busy
);

    // ****************************************************************
    // Declarations
    // ****************************************************************
    reg [7:0] general_io_port;
    reg [7:0] mem [0:`SEWS_MEM_DEPTH-1];
    reg [`SEWS_PTR_W-1:0] ptr;
    reg [2:0] state;
    reg [3:0] bit_cnt;
    reg [7:0] rx_shift;
    reg [7:0] tx_shift;
    reg [7:0] data_buf;
    reg have_data;
    reg in_ack;
    reg ack_given;
    reg is_read;
    reg mem_pull;
    reg master_ack;
    reg scl_q;
    reg sda_q;
    reg busy;
    reg [`SEWS_BUSY_W-1:0] busy_cnt;
    wire scl_rise;
    wire scl_fall;
    wire start_seen;
    wire stop_seen;
    wire [7:0] rx_byte;
    wire commit;
    wire apb_setup;
    wire apb_write;
    wire addr_ok;
    integer i;

    // Slave states, binary coded
    localparam [2:0] ST_IDLE = `SEWS_ST_IDLE;
    localparam [2:0] ST_CTRL = `SEWS_ST_CTRL;
    localparam [2:0] ST_ADDR = `SEWS_ST_ADDR;
    localparam [2:0] ST_DATA = `SEWS_ST_DATA;
    localparam [2:0] ST_TX = `SEWS_ST_TX;
    localparam [2:0] ST_MACK = `SEWS_ST_MACK;

    // Decode of the two implemented word addresses
    function is_mapped;
        input [`SEWS_ADDR_W-1:0] a;
        begin
            is_mapped = (a == `SEWS_ADDR_PORT) || (a == `SEWS_ADDR_STAT);
        end
    endfunction

    // Device code field of a control byte against this memory's code
    function ctrl_match;
        input [7:0] b;
        begin
            ctrl_match = (b[`SEWS_CODE_HI:`SEWS_CODE_LO] == `SEWS_DEV_CODE);
        end
    endfunction

    // ****************************************************************
    // Serial lines
    // ****************************************************************
    // Clock is push-pull straight from the port bit; data is a wired-AND
    // of the port bit (pulls low only) and the memory's own pull-down,
    // the pull-up giving one when nobody pulls
    assign scl_line = general_io_port[`SEWS_PORT_SCL];
    assign sda_line = general_io_port[`SEWS_PORT_SDA] & ~mem_pull;
    assign mem_busy = busy;

    // ****************************************************************
    // APB slave
    // ****************************************************************
    // No wait states: every access finishes in its first access cycle
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~addr_ok;
    assign addr_ok = is_mapped(paddr);
    assign apb_setup = psel & ~penable;
    assign apb_write = psel & penable & pwrite & addr_ok;

    // Port register; bits 7 and 6 drive the serial lines
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            general_io_port <= `SEWS_PORT_RST;
        end else if (apb_write && paddr == `SEWS_ADDR_PORT) begin
            general_io_port <= pwdata[7:0];
        end
    end

    // Read data captured in setup so it is stable through the access phase;
    // line bits read the live wire, so software sees the memory's answer
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= {`SEWS_DATA_W{1'b0}};
        end else if (apb_setup) begin
            prdata <= {`SEWS_DATA_W{1'b0}};
            if (paddr == `SEWS_ADDR_PORT) begin
                prdata[7:0] <= {scl_line, sda_line, general_io_port[5:0]};
            end else if (paddr == `SEWS_ADDR_STAT) begin
                prdata[`SEWS_STAT_BUSY] <= busy;
                prdata[`SEWS_STAT_PTR_HI:`SEWS_STAT_PTR_LO] <= ptr;
            end
        end
    end

    // ****************************************************************
    // Bus condition detection
    // ****************************************************************
    // Lines are made on this clock, so one stage of history is enough
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_line;
            sda_q <= sda_line;
        end
    end

    assign scl_rise = scl_line & ~scl_q;
    assign scl_fall = ~scl_line & scl_q;
    // Data edges during clock high are never data bits; both conditions
    // need the clock high on two samples, so a clock edge and a data edge
    // written together in one port write never look like a start or stop
    assign start_seen = scl_line & scl_q & sda_q & ~sda_line;
    assign stop_seen = scl_line & scl_q & ~sda_q & sda_line;
    assign rx_byte = rx_shift;
    // The held byte commits only while no later bit has been completed;
    // the stop itself follows a clock rise that looks like a new bit
    assign commit = stop_seen && state == ST_DATA && have_data && !in_ack;

    // ****************************************************************
    // Self-timed write cycle
    // ****************************************************************
    // Store happens at once; busy only blocks the bus for the cycle time.
    // Limitation: a reset in mid-cycle ends busy early, the byte is kept
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy <= 1'b0;
            busy_cnt <= {`SEWS_BUSY_W{1'b0}};
        end else if (commit) begin
            busy <= 1'b1;
            busy_cnt <= WRITE_CYCLES[`SEWS_BUSY_W-1:0] - 1'b1;
        end else if (busy) begin
            if (busy_cnt == {`SEWS_BUSY_W{1'b0}}) begin
                busy <= 1'b0;
            end else begin
                busy_cnt <= busy_cnt - 1'b1;
            end
        end
    end

    // ****************************************************************
    // Storage array
    // ****************************************************************
    // Storage array; no reset, contents are non-volatile in intent
    always @(posedge pclk) begin
        if (commit) begin
            mem[ptr] <= data_buf;
        end
    end

    // ****************************************************************
    // Serial slave state machine
    // ****************************************************************
    // Start wins over everything else, stop ends any state; bits are
    // shifted on clock rise, the answer bit changes on clock fall
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ST_IDLE;
            bit_cnt <= 4'h0;
            rx_shift <= 8'h00;
            tx_shift <= 8'h00;
            data_buf <= 8'h00;
            have_data <= 1'b0;
            in_ack <= 1'b0;
            ack_given <= 1'b0;
            is_read <= 1'b0;
            mem_pull <= 1'b0;
            master_ack <= 1'b0;
            ptr <= {`SEWS_PTR_W{1'b0}};
        end else if (start_seen) begin
            state <= ST_CTRL;
            bit_cnt <= 4'h0;
            in_ack <= 1'b0;
            have_data <= 1'b0;
            mem_pull <= 1'b0;
        end else if (stop_seen) begin
            state <= ST_IDLE;
            bit_cnt <= 4'h0;
            in_ack <= 1'b0;
            have_data <= 1'b0;
            mem_pull <= 1'b0;
        end else if (in_ack) begin
            // Pull held from fall to fall covers the whole high phase
            if (scl_fall) begin
                in_ack <= 1'b0;
                bit_cnt <= 4'h0;
                mem_pull <= 1'b0;
                if (!ack_given) begin
                    // Refused control byte: stay off the bus until a start
                    state <= ST_IDLE;
                end else begin
                    case (state)
                        ST_CTRL: begin
                            if (is_read) begin
                                state <= ST_TX;
                                tx_shift <= mem[ptr];
                                mem_pull <= ~mem[ptr][7];
                            end else begin
                                state <= ST_ADDR;
                            end
                        end
                        ST_ADDR: begin
                            state <= ST_DATA;
                        end
                        default: begin
                            state <= state;
                        end
                    endcase
                end
            end
        end else begin
            case (state)
                ST_CTRL, ST_ADDR, ST_DATA: begin
                    if (scl_rise) begin
                        rx_shift <= {rx_shift[6:0], sda_line};
                        bit_cnt <= bit_cnt + 4'h1;
                    end else if (scl_fall && bit_cnt == `SEWS_BITS_PER_BYTE) begin
                        in_ack <= 1'b1;
                        case (state)
                            ST_CTRL: begin
                                is_read <= rx_byte[`SEWS_RW_BIT];
                                ack_given <= ctrl_match(rx_byte) && !busy;
                                mem_pull <= ctrl_match(rx_byte) && !busy;
                            end
                            ST_ADDR: begin
                                ptr <= rx_byte[`SEWS_PTR_W-1:0];
                                ack_given <= 1'b1;
                                mem_pull <= 1'b1;
                            end
                            default: begin
                                data_buf <= rx_byte;
                                have_data <= 1'b1;
                                ack_given <= 1'b1;
                                mem_pull <= 1'b1;
                            end
                        endcase
                    end else if (scl_fall && state == ST_DATA && bit_cnt == 4'h1) begin
                        // A finished first bit of a further byte drops the held one;
                        // a stop's own clock rise never gets here, so it still commits
                        have_data <= 1'b0;
                    end
                end
                ST_TX: begin
                    // Bits leave on clock fall so they are stable while high
                    if (scl_fall) begin
                        if (bit_cnt == `SEWS_LAST_TX_BIT) begin
                            bit_cnt <= 4'h0;
                            mem_pull <= 1'b0;
                            ptr <= ptr + 1'b1;
                            state <= ST_MACK;
                        end else begin
                            bit_cnt <= bit_cnt + 4'h1;
                            tx_shift <= {tx_shift[6:0], 1'b0};
                            mem_pull <= ~tx_shift[6];
                        end
                    end
                end
                ST_MACK: begin
                    if (scl_rise) begin
                        master_ack <= ~sda_line;
                    end else if (scl_fall) begin
                        if (master_ack) begin
                            state <= ST_TX;
                            tx_shift <= mem[ptr];
                            mem_pull <= ~mem[ptr][7];
                        end else begin
                            // Line stays released for the master's stop
                            state <= ST_IDLE;
                            mem_pull <= 1'b0;
                        end
                    end
                end
                default: begin
                    state <= ST_IDLE;
                    mem_pull <= 1'b0;
                end
            endcase
        end
    end

    // Erased cells read all ones at simulation start; real storage
    // keeps whatever was last written across power cycles
    initial begin
        for (i = 0; i < `SEWS_MEM_DEPTH; i = i + 1) begin
            mem[i] = 8'hFF;
        end
    end

endmodule

/* File: design/sews_eeprom_map.vh */
`ifndef SEWS_EEPROM_MAP_VH
`define SEWS_EEPROM_MAP_VH

// ****************************************************************
// Register indices and byte addresses
// ****************************************************************
// Printed offset 06h is not a multiple of four: it is an index
`define SEWS_IDX_PORT 6
`define SEWS_IDX_STAT 7
`define SEWS_ADDR_PORT 8'h18
`define SEWS_ADDR_STAT 8'h1C
`define SEWS_ADDR_W 8
`define SEWS_DATA_W 32

// ****************************************************************
// Port register layout and reset value
// ****************************************************************
`define SEWS_PORT_SDA 6
`define SEWS_PORT_SCL 7
`define SEWS_PORT_RST 8'hFF

// ****************************************************************
// Status register layout
// ****************************************************************
`define SEWS_STAT_BUSY 0
`define SEWS_STAT_PTR_LO 1
`define SEWS_STAT_PTR_HI 4

// ****************************************************************
// Memory geometry and control byte
// ****************************************************************
`define SEWS_MEM_DEPTH 16
`define SEWS_PTR_W 4
`define SEWS_DEV_CODE 4'hA
`define SEWS_CODE_HI 7
`define SEWS_CODE_LO 4
`define SEWS_RW_BIT 0
`define SEWS_BITS_PER_BYTE 4'h8
`define SEWS_LAST_TX_BIT 4'h7

// ****************************************************************
// Self-timed write cycle
// ****************************************************************
`define SEWS_TWR_US 4000
`define SEWS_CLK_MHZ 200
`define SEWS_BUSY_W 20

// ****************************************************************
// Slave states
// ****************************************************************
`define SEWS_ST_IDLE 3'h0
`define SEWS_ST_CTRL 3'h1
`define SEWS_ST_ADDR 3'h2
`define SEWS_ST_DATA 3'h3
`define SEWS_ST_TX 3'h4
`define SEWS_ST_MACK 3'h5

`endif

/* File: verification/sews_eeprom_monitor.sv */
`timescale 1ns/1ps
`include "sews_eeprom_map.vh"

module sews_monitor #(
    parameter WRITE_CYCLES = 50
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [`SEWS_ADDR_W-1:0] paddr,
    input wire [`SEWS_DATA_W-1:0] pwdata,
    input wire [`SEWS_DATA_W-1:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire scl_line,
    input wire sda_line,
    input wire mem_busy
);
    reg sda_out;
    reg [31:0] busy_cnt;
    wire port_wr = psel && penable && pwrite && pready && paddr == `SEWS_ADDR_PORT;
    wire scl_req = pwdata[`SEWS_PORT_SCL];
    wire sda_req = pwdata[`SEWS_PORT_SDA];
    wire mapped = paddr == `SEWS_ADDR_PORT || paddr == `SEWS_ADDR_STAT;

    // Shadow of the master's data bit, and length of the write cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sda_out <= 1'b1;
            busy_cnt <= 32'h0;
        end else begin
            if (port_wr) begin
                sda_out <= sda_req;
            end
            busy_cnt <= mem_busy ? busy_cnt + 32'h1 : 32'h0;
        end
    end

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_port_wr;
        psel && penable && pwrite && paddr == `SEWS_ADDR_PORT;
    endsequence

    AST_PREADY: assert property (s_setup ##1 (psel && penable) |-> pready)
        else $error("access phase without ready");
    AST_SLVERR: assert property (psel && penable |-> pslverr == !mapped)
        else $error("error response wrong for address");
    AST_SCL_SET: assert property (s_port_wr |=> scl_line == $past(scl_req))
        else $error("clock line does not follow port bit");
    AST_SCL_HOLD: assert property ($changed(scl_line) |-> $past(port_wr))
        else $error("clock line moved without a port write");
    AST_SDA_LOW: assert property (s_port_wr ##0 !sda_req |=> !sda_line)
        else $error("data line not pulled low");
    AST_RST_LINES: assert property ($rose(presetn) |-> scl_line && sda_line && !mem_busy)
        else $error("lines not high after reset");
    AST_BUSY_START: assert property ($rose(mem_busy) |-> scl_line && sda_line)
        else $error("write cycle began without stop");
    AST_BUSY_LEN: assert property ($fell(mem_busy) |-> busy_cnt == WRITE_CYCLES)
        else $error("write cycle length wrong");
    AST_NO_ACK_BUSY: assert property (mem_busy && sda_out |-> sda_line)
        else $error("memory drove data line while busy");
    AST_HIGH_STABLE: assert property (scl_line && $past(scl_line) && $stable(sda_out) |-> $stable(sda_line))
        else $error("data line moved while clock high");
endmodule

/* File: verification/sews_eeprom_tb.sv */
`timescale 1ns/1ps
`include "sews_eeprom_map.vh"

module sews_eeprom_tb;
    // Short write cycle, still longer than one polling attempt
    localparam int WC = 1500;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    wire psel, penable, pwrite, pready, pslverr, scl_line, sda_line, mem_busy, hang;
    wire [7:0] paddr;
    wire [31:0] pwdata, prdata;
    int fail_count = 0;
    int checked = 0;
    logic a;
    logic [7:0] v;

    sews_eeprom #(.WRITE_CYCLES(WC)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .scl_line(scl_line), .sda_line(sda_line),
        .mem_busy(mem_busy));
    sews_host host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .hang(hang));

    initial forever #2.5 pclk = ~pclk;

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    task stop_test;
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task rdc(input logic [7:0] ad, input logic [31:0] e);
        host.xfer(1'b0, ad, 32'h0);
        chk(host.q, e);
    endtask
    // Random read: pointer set by a write header, then restart
    task mread(input logic [7:0] ad, output logic [7:0] d);
        host.start;
        host.tx(8'hA0, a);
        host.tx(ad, a);
        host.start;
        host.tx(8'hA1, a);
        host.rx(d);
        host.stop;
    endtask
    task hdr(input logic [7:0] ad);
        host.start;
        host.tx(8'hA0, a);
        host.tx(ad, a);
    endtask

    // A stuck handshake ends the run
    always @(posedge hang) begin
        fail_count++;
        stop_test;
    end

    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rdc(`SEWS_ADDR_PORT, 32'hFF);
        host.xfer(1'b1, `SEWS_ADDR_STAT, 32'hFFFFFFFF);
        rdc(`SEWS_ADDR_STAT, 32'h0);
        rdc(8'h40, 32'h0);
        chk({31'h0, host.err}, 32'h1);
        // Byte write, upper address bits ignored
        host.start;
        host.tx(8'hA0, a);
        chk(a, 0);
        host.tx(8'hF5, a);
        chk(a, 0);
        host.tx(8'h3C, a);
        chk(a, 0);
        host.stop;
        chk({31'h0, mem_busy}, 32'h1);
        rdc(`SEWS_ADDR_STAT, 32'hB);
        host.start;
        host.tx(8'hA0, a);
        chk(a, 1);
        host.stop;
        host.poll;
        rdc(`SEWS_ADDR_STAT, 32'hA);
        host.start;
        host.tx(8'hA1, a);
        chk(a, 0);
        host.rx(v);
        chk(v, 8'h3C);
        host.stop;
        // Foreign device code
        host.start;
        host.tx(8'hB0, a);
        chk(a, 1);
        host.stop;
        // Stop partway through the only data byte
        hdr(8'h02);
        host.bits(8'h99, 4);
        host.stop;
        rdc(`SEWS_ADDR_STAT, 32'h4);
        mread(8'h02, v);
        chk(v, 8'hFF);
        // Second full byte replaces the first
        hdr(8'h09);
        host.tx(8'h12, a);
        host.tx(8'h34, a);
        chk(a, 0);
        host.stop;
        host.poll;
        mread(8'h09, v);
        chk(v, 8'h34);
        // Stop partway through a later byte
        hdr(8'h07);
        host.tx(8'h55, a);
        host.bits(8'h66, 3);
        host.stop;
        rdc(`SEWS_ADDR_STAT, 32'hE);
        mread(8'h07, v);
        chk(v, 8'hFF);
        stop_test;
    end
endmodule

bind sews_eeprom sews_monitor #(.WRITE_CYCLES(WRITE_CYCLES)) u_mon (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_line(scl_line),
    .sda_line(sda_line), .mem_busy(mem_busy));

/* File: verification/sews_host.sv */
`timescale 1ns/1ps
`include "sews_eeprom_map.vh"

// ****************************************************************
// Core model toggling the port bits over APB
// ****************************************************************
module sews_host (
    input wire pclk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    output logic hang
);
    logic err;
    logic [31:0] q;

    // Bus idle from time zero
    initial begin
        {psel, penable, pwrite, paddr, pwdata, hang} = '0;
    end

    // One transfer, held until ready is seen; starts at a rising edge
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) hang <= 1'b1;
        q = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
        @(posedge pclk);
    endtask

    // Pacing stretches each bit to roughly 160 ns
    task setl(input logic c, input logic s);
        xfer(1'b1, `SEWS_ADDR_PORT, {24'h0, c, s, 6'h00});
        repeat (8) @(posedge pclk);
    endtask
    task start;
        setl(1, 1);
        setl(1, 0);
        setl(0, 0);
    endtask
    task stop;
        setl(0, 0);
        setl(1, 0);
        setl(1, 1);
    endtask
    // Data changes only with the clock low
    task bits(input logic [7:0] v, input int n);
        for (int i = 7; i > 7 - n; i--) begin
            setl(0, v[i]);
            setl(1, v[i]);
            setl(0, v[i]);
        end
    endtask
    // Ninth pulse with the line released, read while clock high
    task tx(input logic [7:0] v, output logic ack);
        bits(v, 8);
        setl(0, 1);
        setl(1, 1);
        xfer(1'b0, `SEWS_ADDR_PORT, 32'h0);
        ack = q[`SEWS_PORT_SDA];
        setl(0, 1);
    endtask
    // Eight bits in, last one left unacknowledged
    task rx(output logic [7:0] v);
        v = 8'h00;
        repeat (8) begin
            setl(1, 1);
            xfer(1'b0, `SEWS_ADDR_PORT, 32'h0);
            v = {v[6:0], q[`SEWS_PORT_SDA]};
            setl(0, 1);
        end
        setl(1, 1);
        setl(0, 1);
    endtask
    // Retry start plus write control until acknowledged
    task poll;
        logic a;
        int n;
        a = 1'b1;
        n = 0;
        while (a !== 1'b0 && n < 10) begin
            start;
            tx(8'hA0, a);
            stop;
            n++;
        end
        if (a !== 1'b0) hang <= 1'b1;
    endtask
endmodule
